// ===== verilog/abtc_defines.svh
`ifndef ABTC_DEFINES_SVH
`define ABTC_DEFINES_SVH

// ****************************************************************
// register map on the special-function register bus
// ****************************************************************
`define ABTC_SFR_PAGE          4'hF
`define ABTC_ADDR_PWRUP        8'hBA
`define ABTC_ADDR_TRACK        8'hBD
`define ABTC_PWRUP_RST         8'h0F
`define ABTC_TRACK_RST         8'h16
`define ABTC_PWRUP_FIELD_MSB   3
`define ABTC_TRACK_FIELD_MSB   5

// ****************************************************************
// timing
// ****************************************************************
`define ABTC_CLK_PERIOD_NS     100
`define ABTC_PWRUP_UNIT_NS     400
`define ABTC_TRACK_UNIT_NS     50
`define ABTC_TRACK_BASE        64
`define ABTC_DTRACK_SAR_CYC    3

`endif

// ===== verilog/abtc_pkg.sv
`default_nettype none

package abtc_pkg;
    typedef enum logic [1:0] {
        ABTC_IDLE,
        ABTC_PWRUP,
        ABTC_TRACK,
        ABTC_CONV
    } abtc_state_e;

    typedef logic [7:0] abtc_cnt_t;
endpackage

`default_nettype wire

// ===== verilog/abtc_delay_timer.sv
`default_nettype none

// ****************************************************************
// down-counter; expired is high while the count stands at zero
// ****************************************************************
module abtc_delay_timer #(
    parameter int WIDTH = 8
) (
    input  wire logic             clk,
    input  wire logic             sys_rst,
    input  wire logic             load,
    input  wire logic [WIDTH-1:0] load_val,
    output logic                  expired
);
    logic [WIDTH-1:0] cnt_reg;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cnt_reg <= '0;
        end else if (load) begin
            cnt_reg <= load_val;
        end else if (cnt_reg != '0) begin
            cnt_reg <= cnt_reg - WIDTH'(1);
        end
    end

    assign expired = (cnt_reg == '0);
endmodule

`default_nettype wire

// ===== verilog/abtc_top.sv
`include "abtc_defines.svh"
`default_nettype none

// Function
// - bits 6:4 of the power-up register read as zero and writes to them are dropped.
// - with burst mode off the converter power follows the converter enable and no power-up delay applies.
// - with burst mode on and the converter enabled, power stays on after a burst.
// - with burst mode on and the converter enabled, conversion starts without a power-up delay.
// - with burst mode on and the converter disabled, power drops after a burst and the next one waits the power-up delay.
// - the power-up delay is (field + 1) times 400 ns.
// - between burst conversions the tracking delay is (64 - field) times 50 ns.
// - delayed tracking adds three conversion-clock cycles of tracking before every conversion.
// - the burst tracking delay is skipped before the first conversion of a burst.
// - bits 7:6 of the track register read as zero and writes to them are dropped.
// - with burst mode on the converter timing clock is taken from the low power oscillator.
// - a burst performs 1, 4, 8, 16, 32 or 64 conversions as the repeat field selects.
module abtc_top #(
    parameter int CNT_W = 8
) (
    input  wire logic       clk,
    input  wire logic       sys_rst,
    input  wire logic [3:0] sfr_page,
    input  wire logic [7:0] sfr_addr,
    input  wire logic       sfr_wr,
    input  wire logic       sfr_rd,
    input  wire logic [7:0] sfr_wdata,
    output logic      [7:0] sfr_rdata_reg,
    input  wire logic       burst_mode_enable,
    input  wire logic       converter_enable,
    input  wire logic       delayed_track_select,
    input  wire logic [2:0] burst_repeat_count,
    input  wire logic [4:0] sar_clk_div,
    input  wire logic       start_conv,
    input  wire logic       conv_done,
    output logic            conv_power_on_reg,
    output logic            conv_start_reg,
    output logic            timing_clk_sel_reg,
    output logic            burst_busy_reg,
    output logic            burst_done_reg
);
    // ****************************************************************
    // helpers
    // ****************************************************************
    // rounds up so a programmed delay is never cut short
    function automatic int ns_to_cyc(input int ns);
        ns_to_cyc = (ns + `ABTC_CLK_PERIOD_NS - 1) / `ABTC_CLK_PERIOD_NS;
    endfunction

    // reserved repeat codes fall back to a single conversion
    function automatic logic [6:0] repeat_target(input logic [2:0] code);
        case (code)
            3'h1:    repeat_target = 7'h04;
            3'h2:    repeat_target = 7'h08;
            3'h3:    repeat_target = 7'h10;
            3'h4:    repeat_target = 7'h20;
            3'h5:    repeat_target = 7'h40;
            default: repeat_target = 7'h01;
        endcase
    endfunction

    function automatic logic sfr_hit(input logic [3:0] page, input logic [7:0] addr,
                                     input logic [7:0] want);
        sfr_hit = (page == `ABTC_SFR_PAGE) && (addr == want);
    endfunction

    // ****************************************************************
    // registers
    // ****************************************************************
    logic [3:0] pwr_field_reg;
    logic [5:0] trk_field_reg;
    localparam logic [7:0] PWR_RST = `ABTC_PWRUP_RST;
    localparam logic [7:0] TRK_RST = `ABTC_TRACK_RST;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pwr_field_reg <= PWR_RST[`ABTC_PWRUP_FIELD_MSB:0];
            trk_field_reg <= TRK_RST[`ABTC_TRACK_FIELD_MSB:0];
        end else if (sfr_wr) begin
            if (sfr_hit(sfr_page, sfr_addr, `ABTC_ADDR_PWRUP)) begin
                pwr_field_reg <= sfr_wdata[`ABTC_PWRUP_FIELD_MSB:0];
            end
            if (sfr_hit(sfr_page, sfr_addr, `ABTC_ADDR_TRACK)) begin
                trk_field_reg <= sfr_wdata[`ABTC_TRACK_FIELD_MSB:0];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sfr_rdata_reg <= 8'h00;
        end else if (sfr_rd && sfr_hit(sfr_page, sfr_addr, `ABTC_ADDR_PWRUP)) begin
            sfr_rdata_reg <= {4'h0, pwr_field_reg};
        end else if (sfr_rd && sfr_hit(sfr_page, sfr_addr, `ABTC_ADDR_TRACK)) begin
            sfr_rdata_reg <= {2'h0, trk_field_reg};
        end else begin
            sfr_rdata_reg <= 8'h00;
        end
    end

    // ****************************************************************
    // delay arithmetic
    // ****************************************************************
    logic [CNT_W-1:0] pwr_cycles;
    logic [CNT_W-1:0] trk_cycles;
    logic [CNT_W-1:0] dtrk_cycles;
    int               pwr_ns;
    int               trk_ns;

    always_comb begin
        pwr_ns      = (int'(pwr_field_reg) + 1) * `ABTC_PWRUP_UNIT_NS;
        trk_ns      = (`ABTC_TRACK_BASE - int'(trk_field_reg)) * `ABTC_TRACK_UNIT_NS;
        pwr_cycles  = CNT_W'(ns_to_cyc(pwr_ns));
        trk_cycles  = CNT_W'(ns_to_cyc(trk_ns));
        // one conversion clock lasts sar_clk_div + 1 system clocks
        dtrk_cycles = CNT_W'(`ABTC_DTRACK_SAR_CYC * (int'(sar_clk_div) + 1));
    end

    // ****************************************************************
    // burst sequencer
    // ****************************************************************
    abtc_pkg::abtc_state_e state_reg;
    abtc_pkg::abtc_state_e state_next;
    logic                  first_reg;
    logic [6:0]            conv_cnt_reg;
    logic [6:0]            target_reg;
    logic                  tmr_load;
    logic [CNT_W-1:0]      tmr_val;
    logic                  tmr_expired;
    logic                  last_conv;

    abtc_delay_timer #(.WIDTH(CNT_W)) u_timer (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .load     (tmr_load),
        .load_val (tmr_val),
        .expired  (tmr_expired)
    );

    assign last_conv = (conv_cnt_reg + 7'h01) >= target_reg;

    always_comb begin
        state_next = state_reg;
        tmr_load   = 1'b0;
        tmr_val    = '0;
        case (state_reg)
            abtc_pkg::ABTC_IDLE: begin
                if (start_conv) begin
                    tmr_load = 1'b1;
                    if (burst_mode_enable && !converter_enable) begin
                        state_next = abtc_pkg::ABTC_PWRUP;
                        tmr_val    = pwr_cycles;
                    end else begin
                        state_next = abtc_pkg::ABTC_TRACK;
                        tmr_val    = delayed_track_select ? dtrk_cycles : '0;
                    end
                end
            end
            abtc_pkg::ABTC_PWRUP: begin
                if (tmr_expired) begin
                    state_next = abtc_pkg::ABTC_TRACK;
                    tmr_load   = 1'b1;
                    tmr_val    = delayed_track_select ? dtrk_cycles : '0;
                end
            end
            abtc_pkg::ABTC_TRACK: begin
                if (tmr_expired) begin
                    state_next = abtc_pkg::ABTC_CONV;
                end
            end
            abtc_pkg::ABTC_CONV: begin
                if (conv_done) begin
                    if (last_conv) begin
                        state_next = abtc_pkg::ABTC_IDLE;
                    end else begin
                        state_next = abtc_pkg::ABTC_TRACK;
                        tmr_load   = 1'b1;
                        tmr_val    = trk_cycles + (delayed_track_select ? dtrk_cycles : '0);
                    end
                end
            end
            default: begin
                state_next = abtc_pkg::ABTC_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_reg <= abtc_pkg::ABTC_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // repeat target is frozen at the start; a changing field mid-burst is ignored
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            target_reg   <= 7'h01;
            conv_cnt_reg <= 7'h00;
            first_reg    <= 1'b1;
        end else if (state_reg == abtc_pkg::ABTC_IDLE && start_conv) begin
            target_reg   <= burst_mode_enable ? repeat_target(burst_repeat_count) : 7'h01;
            conv_cnt_reg <= 7'h00;
            first_reg    <= 1'b1;
        end else if (state_reg == abtc_pkg::ABTC_CONV && conv_done) begin
            conv_cnt_reg <= conv_cnt_reg + 7'h01;
            first_reg    <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            conv_start_reg <= 1'b0;
            burst_done_reg <= 1'b0;
            burst_busy_reg <= 1'b0;
        end else begin
            conv_start_reg <= (state_reg == abtc_pkg::ABTC_TRACK) && tmr_expired;
            burst_done_reg <= (state_reg == abtc_pkg::ABTC_CONV) && conv_done && last_conv;
            burst_busy_reg <= (state_next != abtc_pkg::ABTC_IDLE);
        end
    end

    // ****************************************************************
    // power and clock selection
    // ****************************************************************
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            conv_power_on_reg <= 1'b0;
        end else if (!burst_mode_enable) begin
            conv_power_on_reg <= converter_enable;
        end else begin
            // low power between bursts only while the enable is clear
            conv_power_on_reg <= converter_enable || (state_next != abtc_pkg::ABTC_IDLE);
        end
    end

    // steers the converter core's clock mux; the oscillator itself never enters this domain
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            timing_clk_sel_reg <= 1'b0;
        end else begin
            timing_clk_sel_reg <= burst_mode_enable;
        end
    end

    // ****************************************************************
    // checks
    // ****************************************************************
    logic [CNT_W-1:0] phase_cnt;
    logic [CNT_W-1:0] last_load;

    always_ff @(posedge clk) begin
        if (sys_rst || state_next != state_reg) begin
            phase_cnt <= '0;
        end else begin
            phase_cnt <= phase_cnt + CNT_W'(1);
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            last_load <= '0;
        end else if (tmr_load) begin
            last_load <= tmr_val;
        end
    end

    sequence pwr_read_s;
        sfr_rd && sfr_hit(sfr_page, sfr_addr, `ABTC_ADDR_PWRUP);
    endsequence

    sequence trk_read_s;
        sfr_rd && sfr_hit(sfr_page, sfr_addr, `ABTC_ADDR_TRACK);
    endsequence

    sequence leave_track_s;
        state_reg == abtc_pkg::ABTC_TRACK && state_next != abtc_pkg::ABTC_TRACK;
    endsequence

    pwr_read_zero_a: assert property (@(posedge clk) disable iff (sys_rst)
        pwr_read_s |=> sfr_rdata_reg[7:4] == 4'h0 && sfr_rdata_reg[3:0] == $past(pwr_field_reg))
        else $error("power-up register read shows wrong bits");

    trk_read_zero_a: assert property (@(posedge clk) disable iff (sys_rst)
        trk_read_s |=> sfr_rdata_reg == {2'h0, $past(trk_field_reg)})
        else $error("track register read shows wrong bits");

    direct_power_a: assert property (@(posedge clk) disable iff (sys_rst)
        !burst_mode_enable |=> conv_power_on_reg == $past(converter_enable))
        else $error("power does not follow converter enable");

    stay_powered_a: assert property (@(posedge clk) disable iff (sys_rst)
        burst_mode_enable && converter_enable |=> conv_power_on_reg)
        else $error("converter powered down while enabled in burst mode");

    immediate_start_a: assert property (@(posedge clk) disable iff (sys_rst)
        state_reg == abtc_pkg::ABTC_IDLE && start_conv && burst_mode_enable
        && converter_enable && !delayed_track_select |-> ##2 conv_start_reg)
        else $error("enabled burst did not start at once");

    low_power_after_a: assert property (@(posedge clk) disable iff (sys_rst)
        burst_done_reg && $past(burst_mode_enable && !converter_enable) |-> !conv_power_on_reg)
        else $error("converter left powered after burst");

    powerup_delay_a: assert property (@(posedge clk) disable iff (sys_rst)
        state_reg == abtc_pkg::ABTC_PWRUP && state_next != abtc_pkg::ABTC_PWRUP
        |-> phase_cnt == pwr_cycles)
        else $error("power-up delay length wrong");

    track_gap_a: assert property (@(posedge clk) disable iff (sys_rst)
        leave_track_s ##0 !first_reg |-> phase_cnt == last_load
        && last_load == trk_cycles + (delayed_track_select ? dtrk_cycles : CNT_W'(0)))
        else $error("track delay between conversions wrong");

    first_track_a: assert property (@(posedge clk) disable iff (sys_rst)
        leave_track_s ##0 first_reg |-> phase_cnt == (delayed_track_select ? dtrk_cycles : '0))
        else $error("first conversion was given the burst track delay");

    repeat_done_a: assert property (@(posedge clk) disable iff (sys_rst)
        state_reg == abtc_pkg::ABTC_CONV && conv_done |=>
        burst_done_reg == ($past(conv_cnt_reg) + 7'h01 >= $past(target_reg)))
        else $error("burst ended at wrong conversion count");

    clk_sel_a: assert property (@(posedge clk) disable iff (sys_rst)
        ##1 timing_clk_sel_reg == $past(burst_mode_enable))
        else $error("timing clock select does not follow burst mode");
endmodule

`default_nettype wire

// ===== dv/abtc_core_model.sv
`default_nettype none

// ****************************************************************
// converter core: answers each start with a done after latency
// ****************************************************************
module abtc_core_model (
    input  wire logic       clk,
    input  wire logic       sys_rst,
    input  wire logic [7:0] latency,
    input  wire logic       conv_start,
    input  wire logic       power_on,
    output logic            conv_done,
    output logic            start_unpowered
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [7:0] remain_reg;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            remain_reg      <= 8'h00;
            conv_done       <= 1'b0;
            start_unpowered <= 1'b0;
        end else begin
            conv_done <= (remain_reg == 8'h01);
            if (conv_start) begin
                remain_reg <= latency;
            end else if (remain_reg != 8'h00) begin
                remain_reg <= remain_reg - 8'h01;
            end
            // a real core converts garbage when started without power
            if (conv_start && !power_on) begin
                start_unpowered <= 1'b1;
            end
        end
    end
endmodule

`default_nettype wire

// ===== dv/tb.sv
`default_nettype none

module tb;
    timeunit 1ns;
    timeprecision 1ns;

    // ****************************************************************
    // stimulus and wiring
    // ****************************************************************
    logic       clk                  = 1'b0;
    logic       sys_rst              = 1'b1;
    logic [3:0] sfr_page             = 4'h0;
    logic [7:0] sfr_addr             = 8'h00;
    logic       sfr_wr               = 1'b0;
    logic       sfr_rd               = 1'b0;
    logic [7:0] sfr_wdata            = 8'h00;
    logic       burst_mode_enable    = 1'b0;
    logic       converter_enable     = 1'b0;
    logic       delayed_track_select = 1'b0;
    logic [2:0] burst_repeat_count   = 3'h0;
    logic [4:0] sar_clk_div          = 5'h00;
    logic       start_conv           = 1'b0;
    logic [7:0] core_latency         = 8'h03;
    wire  logic [7:0] sfr_rdata_reg;
    wire  logic conv_done, conv_power_on_reg, conv_start_reg;
    wire  logic timing_clk_sel_reg, burst_busy_reg, burst_done_reg, core_err;
    int         n_fail      = 0;
    int         comparisons = 0;

    abtc_top u_dut (
        .clk(clk), .sys_rst(sys_rst), .sfr_page(sfr_page), .sfr_addr(sfr_addr),
        .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
        .sfr_rdata_reg(sfr_rdata_reg), .burst_mode_enable(burst_mode_enable),
        .converter_enable(converter_enable), .delayed_track_select(delayed_track_select),
        .burst_repeat_count(burst_repeat_count), .sar_clk_div(sar_clk_div),
        .start_conv(start_conv), .conv_done(conv_done),
        .conv_power_on_reg(conv_power_on_reg), .conv_start_reg(conv_start_reg),
        .timing_clk_sel_reg(timing_clk_sel_reg), .burst_busy_reg(burst_busy_reg),
        .burst_done_reg(burst_done_reg)
    );

    abtc_core_model u_core (
        .clk(clk), .sys_rst(sys_rst), .latency(core_latency), .conv_start(conv_start_reg),
        .power_on(conv_power_on_reg), .conv_done(conv_done), .start_unpowered(core_err)
    );

    initial begin
        forever #50 clk = ~clk;
    end

    // ****************************************************************
    // helpers
    // ****************************************************************
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic test_done;
        $display("comparisons %0d n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    // trailing idle cycle keeps a strobe from being set twice in one step
    task automatic sfr_write(input logic [7:0] a, input logic [3:0] pg, input logic [7:0] d);
        sfr_addr = a; sfr_page = pg; sfr_wdata = d; sfr_wr = 1'b1;
        @(negedge clk) sfr_wr = 1'b0;
        @(negedge clk);
    endtask

    task automatic sfr_read(input logic [7:0] a, input logic [3:0] pg, output logic [7:0] d);
        sfr_addr = a; sfr_page = pg; sfr_rd = 1'b1;
        @(negedge clk) sfr_rd = 1'b0;
        d = sfr_rdata_reg;
        @(negedge clk);
    endtask

    // one start pulse; first latency, last gap and start count are judged
    task automatic run_burst(input logic [15:0] e_first, input logic [15:0] e_gap,
                             input logic [15:0] e_starts, input logic e_pwr);
        int n, since, first, gap, starts;
        logic b1 = 1'b0;
        n = 0; since = 0; first = -1; gap = -1; starts = 0;
        start_conv = 1'b1;
        while (burst_done_reg !== 1'b1 && n < 3000) begin
            @(negedge clk);
            start_conv = 1'b0;
            n++;
            since++;
            if (n == 1) b1 = burst_busy_reg;
            if (conv_start_reg === 1'b1) begin
                starts++;
                if (first < 0) first = n;
                else gap = since;
            end
            if (conv_done === 1'b1) since = 0;
        end
        check("first_latency", first, e_first);
        check("burst_gap", gap, e_gap);
        check("start_count", starts, e_starts);
        check("power_after", conv_power_on_reg, e_pwr);
        // busy rises with the accepted start and is gone when the done pulse shows
        check("busy_level", {b1, burst_busy_reg}, 2'b10);
        @(negedge clk);
    endtask

    // ****************************************************************
    // scenarios
    // ****************************************************************
    task automatic s_regs;
        logic [7:0] d;
        sfr_read(8'hBA, 4'hF, d);
        check("pwrup_reset", d, 8'h0F);
        sfr_read(8'hBD, 4'hF, d);
        check("track_reset", d, 8'h16);
        // top bit stays zero on every power-up register write; only the unused middle bits are exercised
        sfr_write(8'hBA, 4'hF, 8'h7A);
        sfr_read(8'hBA, 4'hF, d);
        check("pwrup_masked", d, 8'h0A);
        sfr_write(8'hBA, 4'h0, 8'h03);
        sfr_read(8'hBA, 4'hF, d);
        check("pwrup_wrong_page", d, 8'h0A);
        sfr_read(8'hBA, 4'h0, d);
        check("read_wrong_page", d, 8'h00);
        sfr_read(8'hBB, 4'hF, d);
        check("read_unmapped", d, 8'h00);
        sfr_write(8'hBD, 4'hF, 8'hE5);
        sfr_read(8'hBD, 4'hF, d);
        check("track_masked", d, 8'h25);
    endtask

    task automatic s_burst_off;
        burst_mode_enable = 1'b0;
        converter_enable = 1'b1;
        repeat (2) @(negedge clk);
        check("power_follows_on", conv_power_on_reg, 1'b1);
        converter_enable = 1'b0;
        repeat (2) @(negedge clk);
        check("power_follows_off", conv_power_on_reg, 1'b0);
        converter_enable = 1'b1;
        burst_repeat_count = 3'h0;
        repeat (2) @(negedge clk);
        run_burst(16'd2, 16'hFFFF, 16'd1, 1'b1);
        check("clk_sel_off", timing_clk_sel_reg, 1'b0);
    endtask

    task automatic s_burst_on;
        logic [7:0] tk[3] = '{8'h3F, 8'h16, 8'h00};
        logic [15:0] gp[3] = '{16'd3, 16'd23, 16'd34};
        logic [15:0] cnt[7] = '{16'd1, 16'd4, 16'd8, 16'd16, 16'd32, 16'd64, 16'd1};
        burst_mode_enable = 1'b1;
        converter_enable = 1'b1;
        burst_repeat_count = 3'h1;
        for (int i = 0; i < 3; i++) begin
            sfr_write(8'hBD, 4'hF, tk[i]);
            run_burst(16'd2, gp[i], 16'd4, 1'b1);
        end
        check("clk_sel_on", timing_clk_sel_reg, 1'b1);
        sfr_write(8'hBD, 4'hF, 8'h3F);
        for (int c = 0; c < 7; c++) begin
            burst_repeat_count = c[2:0];
            run_burst(16'd2, (c == 0 || c == 6) ? 16'hFFFF : 16'd3, cnt[c], 1'b1);
        end
    endtask

    task automatic s_burst_pd;
        logic [3:0] pw[3] = '{4'h0, 4'h3, 4'hF};
        burst_mode_enable = 1'b1;
        converter_enable = 1'b0;
        burst_repeat_count = 3'h1;
        core_latency = 8'h20;
        repeat (2) @(negedge clk);
        check("idle_power_down", conv_power_on_reg, 1'b0);
        for (int i = 0; i < 3; i++) begin
            // power-up span is long enough to cover the first conversion's tracking
            sfr_write(8'hBA, 4'hF, {4'h0, pw[i]});
            // leaving power-up costs one cycle before tracking starts
            run_burst(16'd4 * (pw[i] + 16'd1) + 16'd3, 16'd3, 16'd4, 1'b0);
        end
        core_latency = 8'h03;
    endtask

    task automatic s_dtrack;
        delayed_track_select = 1'b1;
        sar_clk_div = 5'h01;
        burst_mode_enable = 1'b1;
        converter_enable = 1'b1;
        burst_repeat_count = 3'h1;
        run_burst(16'd8, 16'd9, 16'd4, 1'b1);
        burst_mode_enable = 1'b0;
        burst_repeat_count = 3'h0;
        run_burst(16'd8, 16'hFFFF, 16'd1, 1'b1);
        delayed_track_select = 1'b0;
    endtask

    // ****************************************************************
    // main sequence and watchdog
    // ****************************************************************
    initial begin
        repeat (16) @(negedge clk);
        sys_rst = 1'b0;
        s_regs();
        s_burst_off();
        s_burst_on();
        s_burst_pd();
        s_dtrack();
        check("start_while_unpowered", core_err, 1'b0);
        test_done();
    end

    // the whole run needs well under 10k cycles
    initial begin
        #3000000;
        n_fail++;
        test_done();
    end
endmodule

`default_nettype wire
